/* hw/asq_pkg.sv */
package asq_pkg;
  localparam int ASQ_NCH = 16;
  localparam int ASQ_NSLOT = 12;
  localparam int ASQ_DW = 12;
  localparam logic [7:0] ASQ_OFF_MODE = 8'h00;
  localparam logic [7:0] ASQ_OFF_EXT = 8'h04;
  localparam logic [7:0] ASQ_OFF_SEQLO = 8'h08;
  localparam logic [7:0] ASQ_OFF_SEQHI = 8'h0C;
  localparam logic [7:0] ASQ_OFF_CHEN = 8'h10;
  localparam logic [7:0] ASQ_OFF_CHDIS = 8'h14;
  localparam logic [7:0] ASQ_OFF_CHSR = 8'h18;
  localparam logic [7:0] ASQ_OFF_CWR = 8'h1C;
  localparam logic [7:0] ASQ_OFF_DIFFERENTIAL_SELECT = 8'h20;
  localparam logic [7:0] ASQ_OFF_ISR = 8'h24;
  localparam logic [7:0] ASQ_OFF_IMR = 8'h28;
  localparam logic [7:0] ASQ_OFF_LDAT = 8'h2C;
  // Mode register fields
  localparam int ASQ_MR_TRGEN = 0;
  localparam int ASQ_MR_TRGSEL = 1;
  localparam int ASQ_MR_USER_SEQUENCE_ENABLE = 31;
  // Extended mode fields
  localparam int ASQ_EMR_COMPARE_MODE_SELECT = 0;
  localparam int ASQ_EMR_COMPARE_CHANNEL_SELECT = 3;
  localparam int ASQ_EMR_COMPARE_ALL_CHANNELS = 9;
  localparam int ASQ_EMR_FILT = 12;
  localparam int ASQ_EMR_SIGN = 16;
  localparam int ASQ_CWR_HIGH = 16;
  localparam int ASQ_ISR_COMPARE_EVENT_FLAG = 26;
  localparam int ASQ_ISR_DRDY = 24;
  localparam logic [31:0] ASQ_RST_ZERO = 32'h0000_0000;
  typedef enum logic [1:0]
  {
    ASQ_CMP_LOW = 2'b00,
    ASQ_CMP_HIGH = 2'b01,
    ASQ_CMP_IN = 2'b10,
    ASQ_CMP_OUT = 2'b11
  } asq_cmp_e;
endpackage : asq_pkg

/* hw/asq_conv_if.sv */
`timescale 1ns/1ps
interface asq_conv_if;
  logic start;
  logic [3:0] ch;
  logic done;
  logic [11:0] data;
  modport seq (output start, output ch, input done, input data);
  modport cmp (input done, input data, input ch);
endinterface : asq_conv_if

/* hw/asq_window_cmp.sv */
`timescale 1ns/1ps
module asq_window_cmp
  import asq_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  asq_conv_if.cmp cv,
  input wire logic [31:0] emr,
  input wire logic [31:0] cwr,
  output logic hit
);
  logic [3:0] run_reg;
  logic below;
  logic above;
  logic err;
  logic sel;
  logic sgn;
  logic [11:0] lo;
  logic [11:0] hi;
  assign lo = cwr[11:0];
  assign hi = cwr[ASQ_CWR_HIGH +: 12];
  assign sgn = emr[ASQ_EMR_SIGN];
  // Signed compare flips the sign bit so one unsigned compare serves both
  assign below = {cv.data[11] ^ sgn, cv.data[10:0]} < {lo[11] ^ sgn, lo[10:0]};
  assign above = {cv.data[11] ^ sgn, cv.data[10:0]} > {hi[11] ^ sgn, hi[10:0]};
  always_comb
  begin
    unique case (asq_cmp_e'(emr[ASQ_EMR_COMPARE_MODE_SELECT +: 2]))
      ASQ_CMP_LOW: err = below;
      ASQ_CMP_HIGH: err = above;
      ASQ_CMP_IN: err = !below && !above;
      ASQ_CMP_OUT: err = below || above;
    endcase
  end
  assign sel = emr[ASQ_EMR_COMPARE_ALL_CHANNELS] || (cv.ch == emr[ASQ_EMR_COMPARE_CHANNEL_SELECT +: 4]);
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_reg <= 4'h0;
      hit <= 1'b0;
    end
    else
    begin
      hit <= 1'b0;
      if (cv.done && sel)
      begin
        if (!err)
          run_reg <= 4'h0;
        else if (run_reg >= emr[ASQ_EMR_FILT +: 4])
        begin
          hit <= 1'b1;
          run_reg <= 4'h0;
        end
        else
          run_reg <= run_reg + 4'h1;
      end
    end
  end
endmodule : asq_window_cmp

/* hw/asq_sequencer.sv */
`timescale 1ns/1ps
module asq_sequencer
  import asq_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [31:0] mode,
  input wire logic [31:0] slots_lo,
  input wire logic [31:0] slots_hi,
  input wire logic [15:0] chen,
  input wire logic [15:0] diffsel,
  input wire logic trig_tc,
  input wire logic trig_pwm,
  output logic [15:0] mux_pos,
  output logic [15:0] mux_neg,
  output logic busy,
  asq_conv_if.seq cv
);
  logic [3:0] idx_reg;
  logic [3:0] cand;
  logic trig;
  logic [63:0] all_slots;
  logic [3:0] last;
  logic pend_reg;
  assign all_slots = {slots_hi, slots_lo};
  assign trig = mode[ASQ_MR_TRGEN] && (mode[ASQ_MR_TRGSEL] ? trig_pwm : trig_tc);
  assign last = mode[ASQ_MR_USER_SEQUENCE_ENABLE] ? 4'(ASQ_NSLOT - 1) : 4'hF;
  // Order source: user slots or plain channel number
  assign cand = mode[ASQ_MR_USER_SEQUENCE_ENABLE] ? all_slots[idx_reg*4 +: 4] : idx_reg;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_reg <= 4'h0;
      busy <= 1'b0;
      pend_reg <= 1'b0;
      cv.start <= 1'b0;
      cv.ch <= 4'h0;
      mux_pos <= 16'h0000;
      mux_neg <= 16'h0000;
    end
    else
    begin
      cv.start <= 1'b0;
      if (!busy)
      begin
        if (trig)
        begin
          busy <= 1'b1;
          idx_reg <= 4'h0;
          pend_reg <= 1'b0;
        end
        else if (cv.done)
          pend_reg <= 1'b0;
      end
      else if (!pend_reg || cv.done)
      begin
        // A disabled slot issues nothing, so no done would come: step on at once
        pend_reg <= chen[cand];
        if (chen[cand])
        begin
          cv.start <= 1'b1;
          cv.ch <= cand;
          mux_pos <= 16'h0001 << cand;
          mux_neg <= diffsel[cand] ? (16'h0001 << (cand ^ 4'h1)) : 16'h0000;
        end
        if (idx_reg == last)
          busy <= 1'b0;
        else
          idx_reg <= idx_reg + 4'h1;
      end
    end
  end
endmodule : asq_sequencer

/* hw/asq_ctrl.sv */
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module asq_ctrl
  import asq_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic trig_tc,
  input wire logic trig_pwm,
  output logic conv_start,
  output logic [3:0] conv_ch,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic [15:0] mux_pos,
  output logic [15:0] mux_neg,
  output logic dma_req,
  output logic irq
);
  import asq_pkg::*;
  asq_conv_if cv();
  logic [31:0] mode_reg;
  logic [31:0] emr_reg;
  logic [31:0] seqlo_reg;
  logic [31:0] seqhi_reg;
  logic [15:0] chen_reg;
  logic [31:0] cwr_reg;
  logic [15:0] differential_select_reg;
  logic [31:0] imr_reg;
  logic compare_event_flag_reg;
  logic drdy_reg;
  logic [15:0] ldat_reg;
  logic hit;
  logic busy;
  logic [15:0] pos_w;
  logic [15:0] neg_w;
  logic acc;
  logic wr;
  logic rd_isr;
  logic rd_ldat;
  logic [31:0] wmask;
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = acc && wb_we_i;
  assign rd_isr = acc && !wb_we_i && wb_adr_i == ASQ_OFF_ISR;
  assign rd_ldat = acc && !wb_we_i && wb_adr_i == ASQ_OFF_LDAT;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cv.done = conv_done;
  assign cv.data = conv_data;
  asq_sequencer u_seq (
    .mclk(mclk),
    .nrst(nrst),
    .mode(mode_reg),
    .slots_lo(seqlo_reg),
    .slots_hi(seqhi_reg),
    .chen(chen_reg),
    .diffsel(differential_select_reg),
    .trig_tc(trig_tc),
    .trig_pwm(trig_pwm),
    .mux_pos(pos_w),
    .mux_neg(neg_w),
    .busy(busy),
    .cv(cv)
  );
  asq_window_cmp u_cmp (
    .mclk(mclk),
    .nrst(nrst),
    .cv(cv),
    .emr(emr_reg),
    .cwr(cwr_reg),
    .hit(hit)
  );
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= acc;
    end
  end
  // Configuration registers, byte-lane masked writes
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg <= ASQ_RST_ZERO;
      emr_reg <= ASQ_RST_ZERO;
      seqlo_reg <= ASQ_RST_ZERO;
      seqhi_reg <= ASQ_RST_ZERO;
      chen_reg <= 16'h0000;
      cwr_reg <= ASQ_RST_ZERO;
      differential_select_reg <= 16'h0000;
      imr_reg <= ASQ_RST_ZERO;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        ASQ_OFF_MODE: mode_reg <= (mode_reg & ~wmask) | (wb_dat_i & wmask);
        ASQ_OFF_EXT: emr_reg <= (emr_reg & ~wmask) | (wb_dat_i & wmask);
        ASQ_OFF_SEQLO: seqlo_reg <= (seqlo_reg & ~wmask) | (wb_dat_i & wmask);
        ASQ_OFF_SEQHI: seqhi_reg <= (seqhi_reg & ~wmask) | (wb_dat_i & wmask);
        ASQ_OFF_CHEN: chen_reg <= chen_reg | (wb_dat_i[15:0] & wmask[15:0]);
        ASQ_OFF_CHDIS: chen_reg <= chen_reg & ~(wb_dat_i[15:0] & wmask[15:0]);
        ASQ_OFF_CWR: cwr_reg <= (cwr_reg & ~wmask) | (wb_dat_i & wmask);
        ASQ_OFF_DIFFERENTIAL_SELECT: differential_select_reg <= (differential_select_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        ASQ_OFF_IMR: imr_reg <= (imr_reg & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
  end
  // Status flags: a set in the read cycle wins over the read clear
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      compare_event_flag_reg <= 1'b0;
      drdy_reg <= 1'b0;
      ldat_reg <= 16'h0000;
    end
    else
    begin
      if (hit)
        compare_event_flag_reg <= 1'b1;
      else if (rd_isr)
        compare_event_flag_reg <= 1'b0;
      if (conv_done)
      begin
        drdy_reg <= 1'b1;
        ldat_reg <= {conv_ch, conv_data};
      end
      else if (rd_ldat)
        drdy_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_dat_o <= ASQ_RST_ZERO;
    end
    else if (acc && !wb_we_i)
    begin
      unique case (wb_adr_i)
        ASQ_OFF_MODE: wb_dat_o <= mode_reg;
        ASQ_OFF_EXT: wb_dat_o <= emr_reg;
        ASQ_OFF_SEQLO: wb_dat_o <= seqlo_reg;
        ASQ_OFF_SEQHI: wb_dat_o <= seqhi_reg;
        ASQ_OFF_CHSR: wb_dat_o <= {16'h0000, chen_reg};
        ASQ_OFF_CWR: wb_dat_o <= cwr_reg;
        ASQ_OFF_DIFFERENTIAL_SELECT: wb_dat_o <= {16'h0000, differential_select_reg};
        ASQ_OFF_ISR: wb_dat_o <= {5'h00, compare_event_flag_reg, 1'b0, drdy_reg, 7'h00, busy, 16'h0000};
        ASQ_OFF_IMR: wb_dat_o <= imr_reg;
        ASQ_OFF_LDAT: wb_dat_o <= {16'h0000, ldat_reg};
        default: wb_dat_o <= ASQ_RST_ZERO;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_start <= 1'b0;
      conv_ch <= 4'h0;
      mux_pos <= 16'h0000;
      mux_neg <= 16'h0000;
      dma_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      conv_start <= cv.start;
      conv_ch <= cv.ch;
      mux_pos <= pos_w;
      mux_neg <= neg_w;
      dma_req <= conv_done;
      irq <= compare_event_flag_reg && imr_reg[ASQ_ISR_COMPARE_EVENT_FLAG];
    end
  end
endmodule : asq_ctrl

/* sim/asq_ctrl_asserts.sv */
`timescale 1ns/1ps
module asq_ctrl_asserts
  import asq_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_start,
  input wire logic [3:0] conv_ch,
  input wire logic conv_done,
  input wire logic [15:0] mux_pos,
  input wire logic [15:0] mux_neg,
  input wire logic dma_req,
  input wire logic irq
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_nul; wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'hFC && !wb_ack_o |=> wb_dat_o == 32'h0;
  endproperty
  a_nul: assert property (p_nul) else $error("unmapped read");
  property p_dma; conv_done |=> dma_req; endproperty
  a_dma: assert property (p_dma) else $error("dma missing");
  property p_dsrc; dma_req |-> $past(conv_done); endproperty
  a_dsrc: assert property (p_dsrc) else $error("dma spurious");
  property p_st; conv_start |=> !conv_start; endproperty
  a_st: assert property (p_st) else $error("start width");
  property p_pos; conv_start |-> mux_pos == 16'h1 << conv_ch; endproperty
  a_pos: assert property (p_pos) else $error("mux pos");
  property p_neg; conv_start |-> mux_neg == 16'h0 || mux_neg == 16'h1 << (conv_ch ^ 4'h1); endproperty
  a_neg: assert property (p_neg) else $error("mux neg");
  property p_rst; $rose(nrst) |-> mux_neg == 16'h0 && !irq && !conv_start; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  // Quiet converter around the read so a late hit cannot re-raise the flag
  property p_irq; (!conv_done[*3] ##1 (wb_ack_o && !wb_we_i && wb_adr_i == ASQ_OFF_ISR && !conv_done))
    ##1 !conv_done[*2] |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq after read");
  c_differential_select: cover property (conv_start && mux_neg != 16'h0);
  c_irq: cover property ($rose(irq));
  c_dma: cover property (dma_req);
endmodule : asq_ctrl_asserts

bind asq_ctrl asq_ctrl_asserts u_chk (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .conv_start, .conv_ch, .conv_done, .mux_pos, .mux_neg, .dma_req, .irq);

/* sim/asq_conv_model.sv */
`timescale 1ns/1ps
module asq_conv_model
#(
  parameter logic [11:0] BASE = 12'h100
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic [3:0] conv_ch,
  input wire logic [3:0] lat,
  output logic conv_done,
  output logic [11:0] conv_data
);
  logic [4:0] cnt_reg;
  logic [3:0] ch_reg;
  // Data toggles outside done so a stale sample is never taken as a result
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      cnt_reg <= 5'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h0;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start)
      begin
        cnt_reg <= {1'b0, lat} + 5'h1;
        ch_reg <= conv_ch;
      end
      else if (cnt_reg == 5'h1)
      begin
        cnt_reg <= 5'h0;
        conv_done <= 1'b1;
        conv_data <= BASE + {8'h0, ch_reg};
      end
      else if (cnt_reg != 5'h0)
        cnt_reg <= cnt_reg - 5'h1;
    end
endmodule : asq_conv_model

/* sim/asq_ctrl_tb.sv */
`timescale 1ns/1ps
module asq_ctrl_tb;
  import asq_pkg::*;
  typedef struct {logic [31:0] md, ext, cwr; logic fl, mk;} asq_row_s;
  logic mclk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, trig_tc = 1'b0, trig_pwm = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hF, lat = 4'h0, conv_ch;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, e;
  logic wb_ack_o, conv_start, conv_done, dma_req, irq;
  logic [11:0] conv_data;
  logic [15:0] mux_pos, mux_neg;
  int n_mismatch = 0, checks_done = 0, n_dma = 0, k;
  logic [3:0] exp_q[$];
  logic [3:0] user_sequence_enable[11] = '{4'h3, 4'h3, 4'h5, 4'hF, 4'h1, 4'h2, 4'h9, 4'h8, 4'h7, 4'h5, 4'h4};
  // Samples are 0x100 plus channel; thresholds unsigned like the results, except the last row, which sets the sign bit
  asq_row_s rows[9] = '{
    '{32'h3, 32'h2201, 32'h010C_0000, 1'b1, 1'b1},
    '{32'h3, 32'h3201, 32'h010C_0000, 1'b0, 1'b1},
    '{32'h3, 32'h1200, 32'h0000_0103, 1'b1, 1'b0},
    '{32'h3, 32'h0023, 32'h0101_0100, 1'b1, 1'b1},
    '{32'h3, 32'h000B, 32'h0102_00FF, 1'b0, 1'b1},
    '{32'h3, 32'hE202, 32'h0110_00FF, 1'b1, 1'b1},
    '{32'h8000_0001, 32'h3201, 32'h0104_0000, 1'b1, 1'b1},
    '{32'h8000_0001, 32'h4201, 32'h0104_0000, 1'b0, 1'b1},
    '{32'h3, 32'h0001_0200, 32'h0000_0800, 1'b0, 1'b1}};
  always #50 mclk = ~mclk;
  asq_ctrl u_dut (.mclk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .trig_tc, .trig_pwm, .conv_start, .conv_ch, .conv_done, .conv_data, .mux_pos, .mux_neg, .dma_req, .irq);
  asq_conv_model u_cnv (.mclk, .nrst, .conv_start, .conv_ch, .lat, .conv_done, .conv_data);
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++)
      @(posedge mclk);
    rd = wb_dat_o;
    chk("ack", 32'h1, wb_ack_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : wb
  task automatic pulse(logic p);
    trig_tc <= !p;
    trig_pwm <= p;
    @(posedge mclk);
    trig_tc <= 1'b0;
    trig_pwm <= 1'b0;
    @(posedge mclk);
  endtask : pulse
  task automatic run(logic [31:0] md);
    wb(1'b1, ASQ_OFF_MODE, md);
    n_dma = 0;
    pulse(!md[1]);
    repeat (4) @(posedge mclk);
    for (int c = 0; c < 16; c++)
      if (!md[31] && c != 11)
        exp_q.push_back(4'(c));
    if (md[31])
      foreach (user_sequence_enable[j])
        exp_q.push_back(user_sequence_enable[j]);
    pulse(md[1]);
  endtask : run
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  always @(posedge mclk)
  begin
    if (dma_req === 1'b1)
      n_dma++;
    if (conv_start === 1'b1)
    begin
      e = exp_q.size() != 0 ? {28'h0, exp_q.pop_front()} : 32'hFF;
      chk("channel", e, {28'h0, conv_ch});
      chk("mux_pos", 32'h1 << e, {16'h0, mux_pos});
      chk("mux_neg", e == 32'h2 ? 32'h8 : 32'h0, {16'h0, mux_neg});
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    wb(1'b0, ASQ_OFF_DIFFERENTIAL_SELECT, 32'h0);
    chk("differential_select_reset", 32'h0, rd);
    wb(1'b1, ASQ_OFF_DIFFERENTIAL_SELECT, 32'h4);
    wb(1'b1, ASQ_OFF_CHEN, 32'hFFFF);
    wb(1'b1, ASQ_OFF_CHDIS, 32'h0800);
    wb(1'b0, ASQ_OFF_CHSR, 32'h0);
    chk("chsr", 32'hF7FF, rd);
    wb(1'b1, ASQ_OFF_SEQLO, 32'h8921_F533);
    wb(1'b1, ASQ_OFF_SEQHI, 32'h0000_B457);
    wb(1'b1, ASQ_OFF_CWR, 32'h0FFF_0ABC);
    wb(1'b0, ASQ_OFF_CWR, 32'h0);
    chk("cwr", 32'h0FFF_0ABC, rd);
    wb(1'b1, ASQ_OFF_EXT, 32'hF27B);
    wb(1'b0, ASQ_OFF_EXT, 32'h0);
    chk("ext", 32'hF27B, rd);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i])
    begin
      lat <= 4'(i * 2);
      wb(1'b1, ASQ_OFF_EXT, rows[i].ext);
      wb(1'b1, ASQ_OFF_CWR, rows[i].cwr);
      wb(1'b1, ASQ_OFF_IMR, {5'h0, rows[i].mk, 26'h0});
      run(rows[i].md);
      for (k = 0; k < 3000 && n_dma < (rows[i].md[31] ? 11 : 15); k++)
        @(posedge mclk);
      repeat (3) @(posedge mclk);
      chk("dma_count", exp_q.size() + (rows[i].md[31] ? 11 : 15), n_dma);
      chk("irq", rows[i].fl & rows[i].mk, irq);
      wb(1'b0, ASQ_OFF_ISR, 32'h0);
      chk("flag", rows[i].fl, rd[26]);
      wb(1'b0, ASQ_OFF_ISR, 32'h0);
      chk("flag_clear", 32'h0, rd[26]);
    end
    run(32'h3);
    for (k = 0; k < 500 && n_dma < 2; k++)
      @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    exp_q.delete();
    nrst <= 1'b1;
    @(posedge mclk);
    wb(1'b0, ASQ_OFF_DIFFERENTIAL_SELECT, 32'h0);
    chk("differential_select_rerst", 32'h0, rd);
    pulse(1'b0);
    pulse(1'b1);
    repeat (10) @(posedge mclk);
    stop_test();
  end
  initial
  begin
    #3_000_000;
    chk("watchdog", 32'h0, 32'h1);
    stop_test();
  end
endmodule : asq_ctrl_tb
